// ===== tlf_pkg.sv
// Purpose: Shared constants and types for the TDM line framing control
// Assumes: One channel of byte-wide TDM data, one byte per enabled clock
// Notes: Register map is word aligned on a 32-bit classic Wishbone bus
package tlf_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] TLF_OFF_CTRL = 8'h00;
	localparam logic [7:0] TLF_OFF_FILL = 8'h04;
	localparam logic [7:0] TLF_OFF_LOOP = 8'h08;
	localparam logic [7:0] TLF_OFF_CMD = 8'h0C;
	localparam logic [7:0] TLF_OFF_STAT = 8'h10;
	// ==========================================================
	// Field positions
	localparam int TLF_CTRL_LINE = 0;
	localparam int TLF_CTRL_FMODE = 2;
	localparam int TLF_CTRL_ATM = 4;
	localparam int TLF_CTRL_CES = 5;
	localparam int TLF_CTRL_INV = 7;
	localparam int TLF_CTRL_ONES = 8;
	localparam int TLF_CTRL_SHUT = 9;
	localparam int TLF_FILL_PAY = 0;
	localparam int TLF_FILL_SIG = 8;
	localparam int TLF_LOOP_MODE = 0;
	localparam int TLF_LOOP_FEAC = 3;
	localparam int TLF_CMD_ERR = 0;
	// ==========================================================
	// Byte patterns and reset values
	localparam logic [7:0] TLF_FLAG_BYTE = 8'h7E;
	localparam logic [7:0] TLF_ONES_BYTE = 8'hFF;
	localparam logic [7:0] TLF_FILL_RST = 8'hFF;
	localparam logic [7:0] TLF_ERR_MASK = 8'h01;
	localparam logic [4:0] TLF_TIMING_SLOT = 5'h00;
	localparam logic [1:0] TLF_FMODE_DEF = 2'h0;
	localparam logic [1:0] TLF_FMODE_ALT = 2'h1;
	localparam logic [1:0] TLF_FMODE_UNF = 2'h2;
	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		TLF_LT_DS1 = 2'b00,
		TLF_LT_E1 = 2'b01,
		TLF_LT_DS3 = 2'b10,
		TLF_LT_E3 = 2'b11
	} tlf_line_t;
	typedef enum logic [1:0] {
		TLF_CES_NONE = 2'b00,
		TLF_CES_UNSTRUCT = 2'b01,
		TLF_CES_STRUCT = 2'b10,
		TLF_CES_CAS = 2'b11
	} tlf_ces_t;
	typedef enum logic [3:0] {
		TLF_FR_ESF = 4'b0000,
		TLF_FR_BASIC_SF = 4'b0001,
		TLF_FR_DS1_UNF = 4'b0010,
		TLF_FR_E1_CRC4 = 4'b0011,
		TLF_FR_E1_NOCRC = 4'b0100,
		TLF_FR_E1_UNF = 4'b0101,
		TLF_FR_CBIT = 4'b0110,
		TLF_FR_MUX23 = 4'b0111,
		TLF_FR_DS3_UNF = 4'b1000,
		TLF_FR_E3_LEGACY = 4'b1001,
		TLF_FR_E3_NEWER = 4'b1010
	} tlf_frame_t;
	typedef enum logic [2:0] {
		TLF_LP_NONE = 3'b000,
		TLF_LP_LINE = 3'b001,
		TLF_LP_INTERNAL = 3'b010,
		TLF_LP_DL_STD_A = 3'b011,
		TLF_LP_DL_STD_B = 3'b100,
		TLF_LP_PAYLOAD = 3'b101,
		TLF_LP_INB_STD_A = 3'b110,
		TLF_LP_INB_STD_B = 3'b111
	} tlf_loop_t;
endpackage

// ===== tlf_framing_ctrl.sv
// Purpose: Framing, fill, inversion, error insertion and loopback control
// Assumes: Inputs synchronous to clk_i; frame_start_i marks frame boundary
// Notes: Register side takes effect at once; datapath format and fill at frame start, shutdown and loopback at once
//
// What this block does
// R1 - DS-1 modes ESF, superframe, unframed; ESF default
// R2 - E-1 modes CRC4, no CRC4, unframed; CRC4 default
// R3 - E-1 structured: slot 0 timing, else payload
// R4 - Unframed shutdown sends AIS; near end down
// R5 - DS-3 modes C-bit, mux 2-3, unframed; C-bit default
// R6 - E-3 framing fixed by ATM or non-ATM traffic
// R7 - HDLC idle sends 0x7E, or 0xFF if ones
// R8 - ATM ignores idle fill; only default accepted
// R9 - Structured emulation down or under-run: payload fill
// R10 - CAS emulation down or under-run: signalling fill
// R11 - On DS-1/E-1, command injects exactly one test pattern bit error
// R12 - Optional DS-1/E-1 inversion of every data bit, off default
// R13 - Loopback accepted only while channel shut down
// R14 - Line loopback returns received data to line
// R15 - Internal loopback returns local data, line idle
// R16 - DS-1/E-1 request far-end loopback by five methods
// R17 - DS-3/E-3 obey far-end loop only when enabled
// R18 - Loopback leaves other channels undisturbed
// R19 - No loopback after every reset
// R20 - Format changes applied only at frame boundary
`timescale 1ns/10ps
module tlf_framing_ctrl import tlf_pkg::*; #(
	parameter int DATA_W = 8,
	parameter int SLOT_W = 5
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic frame_start_i,
	input wire logic [SLOT_W-1:0] slot_i,
	input wire logic ch_sel_i,
	input wire logic hdlc_idle_i,
	input wire logic ces_up_i,
	input wire logic underrun_i,
	input wire logic bit_error_rate_test_i,
	input wire logic [DATA_W-1:0] tx_byte_i,
	input wire logic [DATA_W-1:0] tx_sig_i,
	input wire logic [DATA_W-1:0] rx_byte_i,
	input wire logic feac_act_i,
	input wire logic feac_deact_i,
	output logic [DATA_W-1:0] line_byte_o,
	output logic [DATA_W-1:0] line_sig_o,
	output logic [DATA_W-1:0] local_byte_o,
	output logic payload_slot_o,
	output logic oper_up_o,
	output logic [2:0] far_loop_req_o,
	output logic line_loop_o,
	output logic internal_loop_o
);
	// ==========================================================
	// Elaboration checks
	generate
		if (DATA_W != 8) begin : g_bad_width
			$error("tlf_framing_ctrl: DATA_W must be 8");
		end
		if (SLOT_W != 5) begin : g_bad_slot
			$error("tlf_framing_ctrl: SLOT_W must be 5");
		end
	endgenerate

	// ==========================================================
	// Register state
	tlf_line_t line_type;
	logic [1:0] fmode;
	logic atm;
	tlf_ces_t ces;
	logic invert;
	logic idle_ones;
	logic shutdown;
	logic [7:0] pay_fill;
	logic [7:0] sig_fill;
	tlf_loop_t loop_mode;
	logic feac_respond;
	logic loop_refused;
	logic err_armed;
	logic remote_loop;
	// Frame-aligned copies used by the datapath
	tlf_line_t act_line;
	tlf_frame_t act_framing;
	tlf_ces_t act_ces;
	logic act_atm;
	logic act_invert;
	logic act_ones;
	logic [7:0] act_pay;
	logic [7:0] act_sig;

	// ==========================================================
	// Wishbone slave
	logic req;
	logic wr_en;
	logic sel_ctrl;
	logic sel_fill;
	logic sel_loop;
	logic sel_cmd;
	logic sel_stat;
	logic arm_cmd;
	logic [31:0] next_rd;
	tlf_frame_t next_framing;

	assign req = wb_cyc_i && wb_stb_i;
	// Write takes effect on the cycle ack is shown
	assign wr_en = req && wb_we_i && wb_ack_o && ce_i;

	// Address decode
	always_comb begin
		sel_ctrl = 1'b0;
		sel_fill = 1'b0;
		sel_loop = 1'b0;
		sel_cmd = 1'b0;
		sel_stat = 1'b0;
		if (wb_adr_i == TLF_OFF_CTRL) begin
			sel_ctrl = 1'b1;
		end else if (wb_adr_i == TLF_OFF_FILL) begin
			sel_fill = 1'b1;
		end else if (wb_adr_i == TLF_OFF_LOOP) begin
			sel_loop = 1'b1;
		end else if (wb_adr_i == TLF_OFF_CMD) begin
			sel_cmd = 1'b1;
		end else if (wb_adr_i == TLF_OFF_STAT) begin
			sel_stat = 1'b1;
		end
	end

	// Read mux; unmapped and write-only words read as zero
	always_comb begin
		next_rd = 32'h0000_0000;
		if (sel_ctrl) begin
			next_rd[TLF_CTRL_LINE +: 2] = line_type;
			next_rd[TLF_CTRL_FMODE +: 2] = fmode;
			next_rd[TLF_CTRL_ATM] = atm;
			next_rd[TLF_CTRL_CES +: 2] = ces;
			next_rd[TLF_CTRL_INV] = invert;
			next_rd[TLF_CTRL_ONES] = idle_ones;
			next_rd[TLF_CTRL_SHUT] = shutdown;
		end else if (sel_fill) begin
			next_rd[TLF_FILL_PAY +: 8] = pay_fill;
			next_rd[TLF_FILL_SIG +: 8] = sig_fill;
		end else if (sel_loop) begin
			next_rd[TLF_LOOP_MODE +: 3] = loop_mode;
			next_rd[TLF_LOOP_FEAC] = feac_respond;
		end else if (sel_stat) begin
			next_rd[3:0] = act_framing;
			next_rd[6:4] = loop_mode;
			next_rd[7] = remote_loop;
			next_rd[8] = oper_up_o;
			next_rd[9] = err_armed;
			next_rd[10] = loop_refused;
		end
	end

	// One wait state ack, dropped the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= req && !wb_ack_o;
			wb_dat_o <= next_rd;
		end
	end

	// ==========================================================
	// Control register; shutdown acts immediately, idle fill at frame start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_type <= TLF_LT_DS1;
			fmode <= TLF_FMODE_DEF; // R1 R2 R5
			atm <= 1'b0;
			ces <= TLF_CES_NONE;
			invert <= 1'b0; // R12
			idle_ones <= 1'b0; // R7
			shutdown <= 1'b1;
		end else if (wr_en && sel_ctrl) begin
			if (wb_sel_i[0]) begin
				line_type <= tlf_line_t'(wb_dat_i[TLF_CTRL_LINE +: 2]);
				fmode <= wb_dat_i[TLF_CTRL_FMODE +: 2];
				atm <= wb_dat_i[TLF_CTRL_ATM];
				ces <= tlf_ces_t'(wb_dat_i[TLF_CTRL_CES +: 2]);
				invert <= wb_dat_i[TLF_CTRL_INV];
			end
			if (wb_sel_i[1]) begin
				// ATM forces flag fill back to its default
				idle_ones <= wb_dat_i[TLF_CTRL_ONES] &&
					!(wb_sel_i[0] ? wb_dat_i[TLF_CTRL_ATM] : atm); // R8
				shutdown <= wb_dat_i[TLF_CTRL_SHUT];
			end else if (wb_sel_i[0] && wb_dat_i[TLF_CTRL_ATM]) begin
				idle_ones <= 1'b0; // R8
			end
		end
	end

	// Fill pattern register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pay_fill <= TLF_FILL_RST; // R9
			sig_fill <= TLF_FILL_RST; // R10
		end else if (wr_en && sel_fill) begin
			if (wb_sel_i[0]) begin
				pay_fill <= wb_dat_i[TLF_FILL_PAY +: 8];
			end
			if (wb_sel_i[1]) begin
				sig_fill <= wb_dat_i[TLF_FILL_SIG +: 8];
			end
		end
	end

	// Loop register; never kept over reset, so boot is unlooped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loop_mode <= TLF_LP_NONE; // R19
			feac_respond <= 1'b0; // R17
			loop_refused <= 1'b0;
		end else if (wr_en && sel_loop && wb_sel_i[0]) begin
			feac_respond <= wb_dat_i[TLF_LOOP_FEAC];
			if (shutdown) begin
				loop_mode <= tlf_loop_t'(wb_dat_i[TLF_LOOP_MODE +: 3]); // R13
				loop_refused <= 1'b0;
			end else begin
				loop_refused <= 1'b1; // R13
			end
		end
	end

	// ==========================================================
	// Framing resolution from line type, mode and traffic
	always_comb begin
		next_framing = TLF_FR_ESF;
		case (line_type)
			TLF_LT_DS1: begin
				if (fmode == TLF_FMODE_ALT) begin
					next_framing = TLF_FR_BASIC_SF; // R1
				end else if (fmode == TLF_FMODE_UNF) begin
					next_framing = TLF_FR_DS1_UNF; // R1
				end else begin
					next_framing = TLF_FR_ESF; // R1
				end
			end
			TLF_LT_E1: begin
				if (fmode == TLF_FMODE_ALT) begin
					next_framing = TLF_FR_E1_NOCRC; // R2
				end else if (fmode == TLF_FMODE_UNF) begin
					next_framing = TLF_FR_E1_UNF; // R2
				end else begin
					next_framing = TLF_FR_E1_CRC4; // R2
				end
			end
			TLF_LT_DS3: begin
				if (fmode == TLF_FMODE_ALT) begin
					next_framing = TLF_FR_MUX23; // R5
				end else if (fmode == TLF_FMODE_UNF) begin
					next_framing = TLF_FR_DS3_UNF; // R5
				end else begin
					next_framing = TLF_FR_CBIT; // R5
				end
			end
			default: begin
				// Mode field ignored: traffic type alone decides
				next_framing = atm ? TLF_FR_E3_NEWER : TLF_FR_E3_LEGACY; // R6
			end
		endcase
	end

	// Apply format only at a frame boundary, never mid-frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_line <= TLF_LT_DS1;
			act_framing <= TLF_FR_ESF;
			act_ces <= TLF_CES_NONE;
			act_atm <= 1'b0;
			act_invert <= 1'b0;
			act_ones <= 1'b0;
			act_pay <= TLF_FILL_RST;
			act_sig <= TLF_FILL_RST;
		end else if (ce_i && frame_start_i) begin
			act_line <= line_type; // R20
			act_framing <= next_framing; // R20
			act_ces <= ces;
			act_atm <= atm;
			act_invert <= invert;
			act_ones <= idle_ones;
			act_pay <= pay_fill;
			act_sig <= sig_fill;
		end
	end

	// ==========================================================
	// Error insertion and far-end loop response
	logic low_rate;
	logic unframed;
	logic timing_slot;
	logic use_data;
	logic use_idle;
	logic err_take;
	logic ces_starved;

	assign low_rate = (act_line == TLF_LT_DS1) || (act_line == TLF_LT_E1);
	assign unframed = (act_framing == TLF_FR_DS1_UNF) ||
		(act_framing == TLF_FR_E1_UNF) || (act_framing == TLF_FR_DS3_UNF);
	assign timing_slot = (act_framing == TLF_FR_E1_CRC4 ||
		act_framing == TLF_FR_E1_NOCRC) && slot_i == TLF_TIMING_SLOT; // R3
	assign arm_cmd = wr_en && sel_cmd && wb_sel_i[0] &&
		wb_dat_i[TLF_CMD_ERR];
	assign ces_starved = !ces_up_i || underrun_i;
	assign line_loop_o = ch_sel_i && (loop_mode == TLF_LP_LINE || remote_loop);
	assign internal_loop_o = ch_sel_i && loop_mode == TLF_LP_INTERNAL;
	assign use_data = ch_sel_i && !line_loop_o && !internal_loop_o &&
		!shutdown && !timing_slot;
	assign use_idle = use_data && act_ces == TLF_CES_NONE && hdlc_idle_i;
	assign err_take = use_data && !use_idle && bit_error_rate_test_i &&
		err_armed;

	// Arm wins over consume so a back-to-back command is not lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_armed <= 1'b0; // R11
		end else if (ce_i) begin
			if (arm_cmd && low_rate) begin
				err_armed <= 1'b1; // R11
			end else if (err_take) begin
				err_armed <= 1'b0; // R11
			end
		end
	end

	// Far-end loop codes act only on DS-3/E-3 with response enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remote_loop <= 1'b0; // R19
		end else if (ce_i) begin
			if (!feac_respond || low_rate) begin
				remote_loop <= 1'b0; // R17
			end else if (feac_act_i) begin
				remote_loop <= 1'b1; // R17
			end else if (feac_deact_i) begin
				remote_loop <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Transmit byte formatting
	logic [7:0] fmt_byte;
	logic [7:0] next_line;
	logic [7:0] next_local;
	logic [7:0] next_sig;

	always_comb begin
		fmt_byte = tx_byte_i;
		if (act_ces == TLF_CES_STRUCT || act_ces == TLF_CES_CAS) begin
			// Unstructured emulation never takes the fill
			if (ces_starved) begin
				fmt_byte = act_pay; // R9
			end
		end else if (use_idle) begin
			fmt_byte = act_ones ? TLF_ONES_BYTE : TLF_FLAG_BYTE; // R7
		end
		if (err_take) begin
			fmt_byte = fmt_byte ^ TLF_ERR_MASK; // R11
		end
		if (act_invert && low_rate) begin
			fmt_byte = ~fmt_byte; // R12
		end
	end

	// Line side selection; other channels pass straight through
	always_comb begin
		if (!ch_sel_i) begin
			next_line = tx_byte_i; // R18
		end else if (line_loop_o) begin
			next_line = rx_byte_i; // R14
		end else if (internal_loop_o) begin
			next_line = TLF_ONES_BYTE; // R15
		end else if (shutdown) begin
			next_line = unframed ? TLF_ONES_BYTE : // R4
				(act_ones ? TLF_ONES_BYTE : TLF_FLAG_BYTE);
		end else if (timing_slot) begin
			next_line = tx_byte_i; // R3
		end else begin
			next_line = fmt_byte;
		end
	end

	// Local side; received data undone from inversion
	always_comb begin
		if (!ch_sel_i) begin
			next_local = rx_byte_i; // R18
		end else if (internal_loop_o) begin
			next_local = fmt_byte; // R15
		end else if (act_invert && low_rate) begin
			next_local = ~rx_byte_i; // R12
		end else begin
			next_local = rx_byte_i;
		end
	end

	// Signalling fill only for emulation with CAS
	always_comb begin
		if (ch_sel_i && act_ces == TLF_CES_CAS && ces_starved) begin
			next_sig = act_sig; // R10
		end else begin
			next_sig = tx_sig_i;
		end
	end

	// Output flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_byte_o <= TLF_ONES_BYTE;
			line_sig_o <= TLF_ONES_BYTE;
			local_byte_o <= TLF_ONES_BYTE;
			payload_slot_o <= 1'b0;
		end else if (ce_i) begin
			line_byte_o <= next_line;
			line_sig_o <= next_sig;
			local_byte_o <= next_local;
			payload_slot_o <= !timing_slot; // R3
		end
	end

	// Status outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oper_up_o <= 1'b0;
			far_loop_req_o <= TLF_LP_NONE;
		end else if (ce_i) begin
			oper_up_o <= !shutdown; // R4
			if (low_rate && loop_mode >= TLF_LP_DL_STD_A) begin
				far_loop_req_o <= loop_mode; // R16
			end else begin
				far_loop_req_o <= TLF_LP_NONE;
			end
		end
	end

	// ==========================================================
	// Assertions
	AST_BOOT_UNLOOPED: assert property (@(posedge clk_i) // R19
		$past(rst_i) && !rst_i |-> loop_mode == TLF_LP_NONE && !remote_loop)
		else $error("loop active after reset");
	AST_LOOP_LOCKED: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		wr_en && sel_loop && wb_sel_i[0] && !shutdown |=>
		$stable(loop_mode) && loop_refused)
		else $error("loop changed while channel up");
	AST_FRAME_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		// Reset reload lands one edge late; not a boundary miss
		!$past(rst_i) && !$stable(act_framing) |->
		$past(ce_i && frame_start_i))
		else $error("framing changed off frame boundary");
	AST_E3_FIXED: assert property (@(posedge clk_i) disable iff (rst_i) // R6
		act_line == TLF_LT_E3 |-> act_framing ==
		(act_atm ? TLF_FR_E3_NEWER : TLF_FR_E3_LEGACY))
		else $error("E-3 framing not fixed by traffic");
	AST_IDLE_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		ce_i && use_idle && !err_take && !(act_invert && low_rate) |=>
		line_byte_o == ($past(act_ones) ? TLF_ONES_BYTE : TLF_FLAG_BYTE))
		else $error("wrong idle byte");
	AST_ATM_NO_ONES: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		atm |-> !idle_ones)
		else $error("ones fill set on ATM");
	AST_LINE_LOOP: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		ce_i && line_loop_o |=> line_byte_o == $past(rx_byte_i))
		else $error("line loop data mismatch");
	AST_ONE_ERROR: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		ce_i && err_take && !arm_cmd |=> !err_armed ##1 !err_armed)
		else $error("error insertion not single");
	AST_FEAC_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // R17
		!remote_loop && !feac_respond |=> !remote_loop)
		else $error("far-end loop obeyed while disabled");
	AST_UNF_AIS: assert property (@(posedge clk_i) disable iff (rst_i) // R4
		ce_i && ch_sel_i && shutdown && unframed && loop_mode == TLF_LP_NONE
		&& !remote_loop |=> line_byte_o == TLF_ONES_BYTE && !oper_up_o)
		else $error("no AIS on unframed shutdown");
	AST_TIMING_SLOT: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		ce_i && timing_slot |=> !payload_slot_o)
		else $error("timing slot marked as payload");
endmodule

// ===== tlf_remote_term.sv
// Purpose: Remote TDM terminal model at the far side of the line
// Assumes: One byte per clock on the line in both directions
// Notes: Far-end loop codes are driven only when the bench asks
`timescale 1ns/10ps
module tlf_remote_term import tlf_pkg::*; #(
	parameter logic [7:0] IDLE_PAT = 8'h3C
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] line_byte_i,
	input wire logic [2:0] far_loop_req_i,
	input wire logic act_req_i,
	input wire logic deact_req_i,
	output logic [7:0] rx_byte_o,
	output logic feac_act_o,
	output logic feac_deact_o
);
	// ==========================================================
	// Far end obeys any loop request by echoing the line back
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_byte_o <= IDLE_PAT;
		end else if (far_loop_req_i != 3'h0) begin
			rx_byte_o <= line_byte_i;
		end else begin
			rx_byte_o <= IDLE_PAT;
		end
	end
	// Loop codes follow the requests one clock late, held as long as they are
	always_ff @(posedge clk_i) begin
		feac_act_o <= act_req_i & ~rst_i;
		feac_deact_o <= deact_req_i & ~rst_i;
	end
endmodule

// ===== test_tlf_framing_ctrl.sv
// Purpose: Self-checking bench for the TDM line framing control
// Assumes: ce_i and all byte lanes held on; one channel under test
// Notes: Every wait is bounded; a spent bound ends the run at once
`timescale 1ns/10ps
module test_tlf_framing_ctrl import tlf_pkg::*;;
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fs = 1'b0, ch = 1'b1;
	logic idle = 1'b0, up = 1'b1, ur = 1'b0, bit_error_rate_test = 1'b0;
	logic act = 1'b0, deact = 1'b0;
	logic [7:0] adr = 8'h00, txb = 8'hA5, txs = 8'h00;
	logic [7:0] rxb, lb, ls, loc;
	logic [4:0] slot = 5'h05;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack, pay, opu, ll, il, fa, fd;
	logic [2:0] flr;
	logic [11:0] cv [11] = '{12'h200, 12'h204, 12'h208, 12'h201,
		12'h205, 12'h209, 12'h202, 12'h206, 12'h20A, 12'h207, 12'h217};
	logic [3:0] fv [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
		4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
	int err_total = 0, checked = 0, i;

	always #50 clk_i = ~clk_i;

	tlf_framing_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .frame_start_i(fs), .slot_i(slot),
		.ch_sel_i(ch), .hdlc_idle_i(idle), .ces_up_i(up),
		.underrun_i(ur), .bit_error_rate_test_i(bit_error_rate_test),
		.tx_byte_i(txb), .tx_sig_i(txs), .rx_byte_i(rxb),
		.feac_act_i(fa), .feac_deact_i(fd), .line_byte_o(lb),
		.line_sig_o(ls), .local_byte_o(loc), .payload_slot_o(pay),
		.oper_up_o(opu), .far_loop_req_o(flr), .line_loop_o(ll),
		.internal_loop_o(il));

	tlf_remote_term far_end (.clk_i(clk_i), .rst_i(rst_i),
		.line_byte_i(lb), .far_loop_req_i(flr), .act_req_i(act),
		.deact_req_i(deact), .rx_byte_o(rxb), .feac_act_o(fa),
		.feac_deact_o(fd));

	// ==========================================================
	// Helpers
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic ed;
		@(posedge clk_i);
	endtask
	// Settled view of outputs one edge after the last drive
	task automatic lat;
		@(posedge clk_i);
		@(negedge clk_i);
	endtask
	// Classic single Wishbone cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		ed;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20) begin
			err_total++;
			print_verdict;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	// New format only lands on a frame boundary pulse
	task automatic frm;
		ed;
		fs <= 1'b1;
		ed;
		fs <= 1'b0;
	endtask
	task automatic feac(input logic a);
		ed;
		act <= a;
		deact <= ~a;
		ed;
		act <= 1'b0;
		deact <= 1'b0;
	endtask
	task automatic done(input string s);
		$display("test %s finished, mismatches so far %0d", s, err_total);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) ed;
		rst_i <= 1'b0;
		lat;
		chk({24'h0, lb}, 32'h7E);
		chk({26'h0, opu, flr, ll, il}, 32'h0);
		rd(TLF_OFF_CTRL, 32'hFFFF, 32'h200);
		rd(TLF_OFF_FILL, 32'hFFFF, 32'hFFFF);
		rd(TLF_OFF_STAT, 32'h7FF, 32'h0);
		done("reset");
		for (i = 0; i < 11; i++) begin
			wr(TLF_OFF_CTRL, {20'h0, cv[i]});
			frm;
			rd(TLF_OFF_STAT, 32'hF, {28'h0, fv[i]});
			lat;
			chk({24'h0, lb}, (cv[i][3:2] == 2'h2) ? 32'hFF : 32'h7E);
		end
		done("framing");
		wr(TLF_OFF_CTRL, 32'h200);
		frm;
		wr(TLF_OFF_LOOP, 32'h1);
		lat;
		chk({22'h0, ll, il, lb}, 32'h23C);
		ed;
		ch <= 1'b0;
		lat;
		chk({23'h0, ll, lb}, {24'h0, txb});
		ed;
		ch <= 1'b1;
		wr(TLF_OFF_LOOP, 32'h2);
		lat;
		chk({15'h0, il, lb, loc}, {16'h1FF, txb});
		for (i = 3; i < 8; i++) begin
			wr(TLF_OFF_LOOP, 32'(i));
			lat;
			chk({29'h0, flr}, 32'(i));
			rd(TLF_OFF_STAT, 32'h70, 32'(i << 4));
			chk({24'h0, rxb}, 32'h7E);
		end
		wr(TLF_OFF_LOOP, 32'h0);
		done("loopback");
		wr(TLF_OFF_CTRL, 32'h0);
		frm;
		wr(TLF_OFF_LOOP, 32'h1);
		lat;
		chk({22'h0, opu, ll, lb}, 32'h2A5);
		rd(TLF_OFF_STAT, 32'h570, 32'h500);
		wr(TLF_OFF_CTRL, 32'h80);
		lat;
		chk({24'h0, lb}, 32'hA5);
		frm;
		lat;
		chk({24'h0, lb}, 32'h5A);
		wr(TLF_OFF_CTRL, 32'h0);
		frm;
		wr(TLF_OFF_CMD, 32'h1);
		rd(TLF_OFF_STAT, 32'h200, 32'h200);
		ed;
		bit_error_rate_test <= 1'b1;
		lat;
		chk({24'h0, lb}, 32'hA4);
		ed;
		bit_error_rate_test <= 1'b0;
		@(negedge clk_i);
		chk({24'h0, lb}, 32'hA5);
		rd(TLF_OFF_STAT, 32'h200, 32'h0);
		done("data");
		ed;
		idle <= 1'b1;
		lat;
		chk({24'h0, lb}, 32'h7E);
		wr(TLF_OFF_CTRL, 32'h100);
		frm;
		lat;
		chk({24'h0, lb}, 32'hFF);
		wr(TLF_OFF_CTRL, 32'h110);
		frm;
		lat;
		chk({24'h0, lb}, 32'h7E);
		ed;
		idle <= 1'b0;
		done("idle");
		wr(TLF_OFF_FILL, 32'h3C5A);
		wr(TLF_OFF_CTRL, 32'h40);
		frm;
		ed;
		up <= 1'b0;
		lat;
		chk({24'h0, lb}, 32'h5A);
		ed;
		up <= 1'b1;
		ur <= 1'b1;
		lat;
		chk({24'h0, lb}, 32'h5A);
		wr(TLF_OFF_CTRL, 32'h60);
		frm;
		lat;
		chk({24'h0, ls}, 32'h3C);
		wr(TLF_OFF_CTRL, 32'h20);
		frm;
		lat;
		chk({24'h0, lb}, {24'h0, txb});
		ed;
		ur <= 1'b0;
		done("fill");
		wr(TLF_OFF_CTRL, 32'h01);
		frm;
		ed;
		slot <= 5'h00;
		lat;
		chk({23'h0, pay, lb}, {24'h0, txb});
		ed;
		slot <= 5'h05;
		lat;
		chk({31'h0, pay}, 32'h1);
		wr(TLF_OFF_CTRL, 32'h09);
		frm;
		ed;
		slot <= 5'h00;
		lat;
		chk({31'h0, pay}, 32'h1);
		done("slots");
		wr(TLF_OFF_CTRL, 32'h02);
		frm;
		feac(1'b1);
		rd(TLF_OFF_STAT, 32'h80, 32'h0);
		wr(TLF_OFF_LOOP, 32'h8);
		feac(1'b1);
		rd(TLF_OFF_STAT, 32'h80, 32'h80);
		feac(1'b0);
		rd(TLF_OFF_STAT, 32'h80, 32'h0);
		done("feac");
		wr(TLF_OFF_CTRL, 32'h200);
		wr(TLF_OFF_LOOP, 32'h1);
		ed;
		rst_i <= 1'b1;
		repeat (2) ed;
		rst_i <= 1'b0;
		rd(TLF_OFF_LOOP, 32'h7, 32'h0);
		chk({31'h0, ll}, 32'h0);
		done("restart");
		print_verdict;
	end
endmodule
